/* File: hdl/sami_map.svh */
// Notes on behaviour
// - Conversion takes eight clocks after addressing.
// - Clock stops only low; state is kept.
// - Output bit changes after each falling edge.
// - Select high floats output and busy flag.
// - Output bit is delayed comparator decision.
// - Positive below negative gives all zeros.
// - Pairs are adjacent channels, polarity selectable.
// - Address word sets inputs, mode and polarity.
// - Single-channel variant takes no address word.
// - Eight-channel common input is shared negative.
// - Four-channel: lower select bit forced one.
// - Two-channel: select forced to one, zero.
// - Leading zeros ignored; start then 2-4 bits.
// - Half clock settle, flag rises, leading zero.
// - Single-ended uses channel against common.
// - Flag drops half clock after conversion.
`ifndef SAMI_MAP_SVH
`define SAMI_MAP_SVH
`define SAMI_VAR_1CH   2'h0
`define SAMI_VAR_2CH   2'h1
`define SAMI_VAR_4CH   2'h2
`define SAMI_VAR_8CH   2'h3
`define SAMI_LEN_1CH   3'h0
`define SAMI_LEN_2CH   3'h2
`define SAMI_LEN_4CH   3'h3
`define SAMI_LEN_8CH   3'h4
`define SAMI_MSB_IDX   3'h7
`define SAMI_SEL_4CH0  1'h1
`define SAMI_SEL_2CH   2'h2
`endif

/* File: hdl/sami_pkg.sv */
package sami_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ADDR   = 5'h02,
    ST_SETTLE = 5'h04,
    ST_CONV   = 5'h08,
    ST_DONE   = 5'h10
  } sami_state_type;

  typedef struct packed {
    logic       single_or_pair_bit;
    logic       odd;
    logic [1:0] sel;
  } sami_addr_type;

  typedef struct packed {
    logic [7:0]      com;
    logic [7:0][7:0] ch;
  } sami_ain_type;

  typedef struct packed {
    sami_addr_type addr;
    logic [7:0]    data;
  } sami_result_type;
endpackage : sami_pkg

/* File: hdl/sami_top.sv */
`timescale 1ns/1ps
`include "sami_map.svh"

module sami_top (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     serial_in_line,
  output logic                          serial_out,
  output logic                          serial_out_oe,
  output logic                          conversion_active_flag,
  output logic                          conversion_active_flag_oe,
  input  wire logic [1:0]               variant,
  input  wire sami_pkg::sami_ain_type   ain,
  output sami_pkg::sami_result_type     result,
  output logic                          result_valid
);
  import sami_pkg::*;

  // Chip select high clears the link state, counters, shift register and pins at once; the result registers and toggle are kept.
  logic frame_rst;
  assign frame_rst = rst | cs_n;

  // Quasi-static inputs cross into the link domain.
  logic [1:0]     var_m_q;
  logic [1:0]     var_s_q;
  sami_ain_type   ain_m_q;
  sami_ain_type   ain_s_q;

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      var_m_q <= 2'h0;
      var_s_q <= 2'h0;
      ain_m_q <= '0;
      ain_s_q <= '0;
    end else begin
      var_m_q <= variant;
      var_s_q <= var_m_q;
      ain_m_q <= ain;
      ain_s_q <= ain_m_q;
    end
  end

  logic [2:0] addr_len;

  always_comb begin
    case (var_s_q)
      `SAMI_VAR_2CH: addr_len = `SAMI_LEN_2CH;
      `SAMI_VAR_4CH: addr_len = `SAMI_LEN_4CH;
      `SAMI_VAR_8CH: addr_len = `SAMI_LEN_8CH;
      default:       addr_len = `SAMI_LEN_1CH;
    endcase
  end

  sami_state_type st_q;
  logic [2:0]     cnt_q;
  logic [2:0]     idx_q;
  logic [3:0]     sh_q;
  logic [7:0]     res_q;
  sami_addr_type  res_addr_q;
  logic           done_tgl_q;

  // State is held on any stopped clock, so a halted low phase loses nothing.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (serial_in_line) begin
            if (addr_len == `SAMI_LEN_1CH) begin
              st_q <= ST_SETTLE;
            end else begin
              st_q <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (cnt_q == 3'h1) begin
            st_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          st_q <= ST_CONV;
        end
        ST_CONV: begin
          if (idx_q == 3'h0) begin
            st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_q <= ST_DONE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Address length counter and conversion bit index.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= 3'h0;
      idx_q <= 3'h0;
    end else begin
      if (st_q == ST_IDLE) begin
        cnt_q <= addr_len;
      end else if (st_q == ST_ADDR) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (st_q == ST_SETTLE) begin
        idx_q <= `SAMI_MSB_IDX;
      end else if (st_q == ST_CONV) begin
        idx_q <= idx_q - 3'h1;
      end
    end
  end

  // Address shift register; the input is ignored outside addressing.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      sh_q <= 4'h0;
    end else if (st_q == ST_ADDR) begin
      sh_q <= {sh_q[2:0], serial_in_line};
    end
  end

  sami_addr_type dec;

  always_comb begin
    case (var_s_q)
      `SAMI_VAR_8CH: begin
        dec = sh_q;
      end
      `SAMI_VAR_4CH: begin
        dec = {sh_q[2:0], `SAMI_SEL_4CH0};
      end
      `SAMI_VAR_2CH: begin
        dec = {sh_q[1:0], `SAMI_SEL_2CH};
      end
      default: begin
        dec = 4'h0;
      end
    endcase
  end

  // The positive input is always channel 2*select+odd; the negative one
  // is the common input or the other member of the same pair.
  logic [2:0] pos_idx;
  logic [2:0] neg_idx;
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  logic [7:0] diff;

  assign pos_idx = {dec.sel, dec.odd};
  assign neg_idx = {dec.sel, ~dec.odd};
  assign pos_v   = ain_s_q.ch[pos_idx];

  always_comb begin
    if (dec.single_or_pair_bit) begin
      neg_v = ain_s_q.com;
    end else begin
      neg_v = ain_s_q.ch[neg_idx];
    end
    if (pos_v > neg_v) begin
      diff = pos_v - neg_v;
    end else begin
      diff = 8'h00;
    end
  end

  // Result is taken after the settle clock and held until the settle clock
  // of the next frame, so the system side may sample it after the toggle crosses.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      res_q      <= 8'h00;
      res_addr_q <= 4'h0;
      done_tgl_q <= 1'b0;
    end else begin
      if (st_q == ST_SETTLE && !cs_n) begin
        res_q      <= diff;
        res_addr_q <= dec;
      end
      if (st_q == ST_CONV && idx_q == 3'h0 && !cs_n) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  logic cur_bit;
  assign cur_bit = res_q[idx_q];

  // Pins change on the falling edge, half a clock after the state moves,
  // which gives the comparator decision its extra settling time.
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      serial_out                <= 1'b0;
      serial_out_oe             <= 1'b0;
      conversion_active_flag    <= 1'b0;
      conversion_active_flag_oe <= 1'b0;
    end else begin
      case (st_q)
        ST_SETTLE: begin
          conversion_active_flag    <= 1'b1;
          conversion_active_flag_oe <= 1'b1;
          serial_out                <= 1'b0;
          serial_out_oe             <= 1'b1;
        end
        ST_CONV: begin
          serial_out <= cur_bit;
        end
        ST_DONE: begin
          conversion_active_flag <= 1'b0;
          serial_out             <= 1'b0;
        end
        default: begin
          serial_out <= serial_out;
        end
      endcase
    end
  end

  // Completion event crosses to the system clock as a toggle.
  logic tgl_m1_q;
  logic tgl_m2_q;
  logic tgl_m3_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_m1_q <= 1'b0;
      tgl_m2_q <= 1'b0;
      tgl_m3_q <= 1'b0;
    end else begin
      tgl_m1_q <= done_tgl_q;
      tgl_m2_q <= tgl_m1_q;
      tgl_m3_q <= tgl_m2_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= tgl_m2_q ^ tgl_m3_q;
      if (tgl_m2_q ^ tgl_m3_q) begin
        result <= {res_addr_q, res_q};
      end
    end
  end

  AST_CONV_LEN: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE) |=> (st_q == ST_CONV) [*8] ##1 (st_q == ST_DONE))
    else $error("Conversion did not last eight clocks.");

  AST_ADDR_LEN: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_IDLE && serial_in_line && var_s_q == `SAMI_VAR_8CH)
    |=> (st_q == ST_ADDR) [*4] ##1 (st_q == ST_SETTLE))
    else $error("Eight-channel address word was not four bits.");

  AST_NO_ADDR: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_IDLE && serial_in_line && var_s_q == `SAMI_VAR_1CH)
    |=> (st_q == ST_SETTLE) && (dec == 4'h0))
    else $error("Single-channel variant took an address word.");

  AST_FLAG_RISE: assert property (@(negedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE) |=> conversion_active_flag && serial_out_oe && !serial_out)
    else $error("Flag or leading zero missing after settle.");

  AST_FLAG_DROP: assert property (@(negedge sclk) disable iff (frame_rst)
    $rose(st_q == ST_DONE) |=> !conversion_active_flag && $past(conversion_active_flag))
    else $error("Flag did not fall half a clock after conversion.");

  AST_BIT_OUT: assert property (@(negedge sclk) disable iff (frame_rst)
    (st_q == ST_CONV) |=> (serial_out == $past(cur_bit)))
    else $error("Output bit is not the current result bit.");

  AST_FLOAT: assert property (@(posedge mclk) disable iff (rst)
    cs_n |-> !serial_out_oe && !conversion_active_flag_oe && (st_q == ST_IDLE))
    else $error("Outputs driven or state kept while deselected.");

  AST_ZERO: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE && pos_v <= neg_v) |=> (res_q == 8'h00))
    else $error("Negative difference did not give zero.");

  AST_PAIR: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE && !dec.single_or_pair_bit)
    |-> ((pos_idx ^ neg_idx) == 3'h1) ##1 (res_addr_q == $past(dec)))
    else $error("Differential pair is not adjacent.");

  AST_COMMON: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE && dec.single_or_pair_bit) |-> (neg_v == ain_s_q.com))
    else $error("Single-ended input not referred to common.");

  AST_VAR4: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE && var_s_q == `SAMI_VAR_4CH) |-> dec.sel[0])
    else $error("Four-channel lower select not forced high.");

  AST_VAR2: assert property (@(posedge sclk) disable iff (frame_rst)
    (st_q == ST_SETTLE && var_s_q == `SAMI_VAR_2CH) |-> (dec.sel == 2'h2))
    else $error("Two-channel select bits not forced.");

endmodule : sami_top

/* File: testbench/sami_ctrl_model.sv */
`timescale 1ns/1ps
module sami_ctrl_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in_line,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  input  wire logic conversion_active_flag,
  input  wire logic conversion_active_flag_oe
);
  int lo_ns = 6;
  // Deselect comes after reset has risen, so the frame clear sees a real edge.
  initial begin
    sclk = 1'b0;
    serial_in_line = 1'b0;
    #2;
    cs_n = 1'b1;
  end
  // The clock only stops in its low phase, and its high phase stays short.
  task automatic tick(input logic di, output logic s, output logic busy);
    serial_in_line = di;
    #(lo_ns - 1);
    s = serial_out;
    busy = serial_out_oe === 1'b1 && conversion_active_flag === 1'b1
           && conversion_active_flag_oe === 1'b1;
    #1;
    sclk = 1'b1;
    #6;
    sclk = 1'b0;
  endtask : tick
  task automatic frame(input logic [3:0] a, input int n, input bit abort,
                       output logic [7:0] d, output logic good);
    logic s;
    logic b;
    good = 1'b1;
    d = 8'h00;
    cs_n = 1'b0;
    repeat (3) tick(1'b0, s, b);
    tick(1'b1, s, b);
    for (int i = n - 1; i >= 0; i--) tick(a[i], s, b);
    // Junk on the data line after addressing must be ignored.
    tick(1'($urandom), s, b);
    good &= (s === 1'b0) && b;
    for (int i = 7; i >= 0 && !(abort && i < 5); i--) begin
      tick(1'($urandom), s, b);
      d[i] = s;
      good &= b;
    end
    if (!abort) begin
      // One clock past the last bit: the output rests at zero and the flag drops.
      tick(1'($urandom), s, b);
      good &= (s === 1'b0) && !b;
    end
    #1;
    if (abort) begin
      d = 8'h00;
    end else begin
      good &= conversion_active_flag === 1'b0 && conversion_active_flag_oe === 1'b1;
    end
    cs_n = 1'b1;
    #2;
    good &= serial_out_oe === 1'b0 && conversion_active_flag_oe === 1'b0;
  endtask : frame
endmodule : sami_ctrl_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import sami_pkg::*;
  logic            mclk;
  logic            rst;
  logic            sclk;
  logic            cs_n;
  logic            serial_in_line;
  logic            serial_out;
  logic            serial_out_oe;
  logic            conversion_active_flag;
  logic            conversion_active_flag_oe;
  logic            result_valid;
  logic [1:0]      variant;
  sami_ain_type    ain;
  sami_result_type result;
  sami_result_type exp_q[$];
  int              num_errors = 0;
  int              check_count = 0;

  sami_top DUT (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_in_line(serial_in_line), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .conversion_active_flag(conversion_active_flag),
    .conversion_active_flag_oe(conversion_active_flag_oe), .variant(variant),
    .ain(ain), .result(result), .result_valid(result_valid));
  sami_ctrl_model partner (.sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conversion_active_flag(conversion_active_flag),
    .conversion_active_flag_oe(conversion_active_flag_oe));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_result(input sami_result_type got, input sami_result_type exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_result

  task automatic chk_serial(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_serial

  function automatic sami_result_type predict(input logic [1:0] v, input logic [3:0] a);
    sami_result_type r;
    logic [7:0]      p;
    logic [7:0]      n;
    case (v)
      2'h3: r.addr = a;
      2'h2: r.addr = {a[2:0], 1'b1};
      2'h1: r.addr = {a[1:0], 2'h2};
      default: r.addr = 4'h0;
    endcase
    p = ain.ch[{r.addr.sel, r.addr.odd}];
    n = r.addr.single_or_pair_bit ? ain.com : ain.ch[{r.addr.sel, ~r.addr.odd}];
    r.data = (p > n) ? p - n : 8'h00;
    return r;
  endfunction : predict

  always @(posedge mclk) begin
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, result, 12'h0);
      end else begin
        chk_result(result, exp_q.pop_front());
      end
    end
  end

  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0]      d;
    logic            g;
    logic [3:0]      a;
    sami_result_type e;
    int              n;
    rst = 1'b0;
    variant = 2'h3;
    ain = '0;
    // Reset rises after time zero so every asynchronous clear sees an edge.
    #1;
    rst = 1'b1;
    void'($urandom(74779));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int t = 0; t < 24; t++) begin
      @(posedge mclk);
      variant <= t[1:0];
      ain <= 72'({$urandom, $urandom, $urandom});
      a = 4'($urandom);
      partner.lo_ns = (t == 6) ? 300 : 6;
      @(posedge mclk);
      n = (t[1:0] == 2'h3) ? 4 : (t[1:0] == 2'h2) ? 3 : (t[1:0] == 2'h1) ? 2 : 0;
      e = predict(t[1:0], a);
      if (t != 9) exp_q.push_back(e);
      partner.frame(a, n, t == 9, d, g);
      chk_serial({g, d}, {1'b1, (t == 9) ? 8'h00 : e.data});
      repeat (5) @(posedge mclk);
      $display("test %0d done", t);
    end
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge mclk);
    if (exp_q.size() != 0) num_errors++;
    report_and_stop();
  end
endmodule : tb
